// File: tb/i2c_bus_model.sv
// Partner model: another master on the two-wire bus, clocking bits at 125 ns each
`timescale 1ns/1ps
module i2c_bus_model
(
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // Both lines released at idle; the clock stands still between frames
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Start: data falls while the clock is high, then the clock goes low
  task automatic start_cond();
    sda_low = 1'b1;
    #62.5 scl = 1'b0;
  endtask
  // Stop: data rises while the clock is high
  task automatic stop_cond();
    #31.25 sda_low = 1'b1;
    #31.25 scl = 1'b1;
    #31.25 sda_low = 1'b0;
    #62.5;
  endtask
  // One bit: data changes only while the clock is low, sampled mid-high
  task automatic clock_bit(input logic b, output logic seen);
    #31.25 sda_low = ~b;
    #31.25 scl = 1'b1;
    #31.25 seen = sda;
    #31.25 scl = 1'b0;
  endtask
  // Eight bits MSB first, then the acknowledge clock; line released after
  task automatic send_byte(input logic [7:0] b, input logic ack_low, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clock_bit(b[i], s);
    clock_bit(~ack_low, ack);
    sda_low = 1'b0;
  endtask
endmodule

// File: tb/i2c_status_flags_tb_top.sv
// Testbench: register port and bus scenarios for the status flags
`timescale 1ns/1ps
module i2c_status_flags_tb_top;
  import i2c_flags_pkg::*;
  logic sys_clk, sys_rst, wr_en, rd_en, tx_bit, tx_drive;
  logic [2:0] addr;
  logic [7:0] wr_data, rd_data;
  logic sda_out, sda_oe, start_req, stop_req, irq, scl, sda_low, ack;
  // Open-drain data line with pull-up: low if either party pulls
  wire sda = ~(sda_low | sda_oe);
  int err_count = 0;
  int checks = 0;
  i2c_status_flags dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .tx_bit(tx_bit), .tx_drive(tx_drive), .start_req(start_req), .stop_req(stop_req), .irq(irq));
  i2c_bus_model bus_u (.sda(sda), .scl(scl), .sda_low(sda_low));
  // Byte comparison
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // One-cycle register write
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= v;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  // Register read and compare; data taken in the cycle after the strobe
  task automatic rc(input string n, input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 chk(n, e, rd_data);
  endtask
  // Let synchronised pin changes reach the flags
  task automatic settle();
    repeat (6) @(posedge sys_clk);
  endtask
  // Collect start/stop request pulses over three cycles
  task automatic req(input logic [1:0] e);
    logic [1:0] s;
    s = 2'b00;
    repeat (3)
    begin
      #1 s = s | {start_req, stop_req};
      @(posedge sys_clk);
    end
    chk("requests", {6'h00, e}, {6'h00, s});
  endtask
  // Reset values and an unmapped index
  task automatic t_reset();
    rc("status", REG_STATUS, 8'h30);
    rc("unmapped", 3'h6, 8'h00);
    rc("events", REG_EVENT, 8'h00);
    chk("sda_out", 8'h00, {7'h00, sda_out});
    $display("test reset done");
  endtask
  // Start and stop seen from another master, with the start interrupt
  task automatic t_busy();
    wr(REG_MASK, 8'h01);
    bus_u.start_cond();
    settle();
    rc("status", REG_STATUS, 8'hb0);
    chk("irq", 8'h01, {7'h00, irq});
    bus_u.stop_cond();
    settle();
    rc("status", REG_STATUS, 8'h30);
    rc("events", REG_EVENT, 8'h03);
    settle();
    chk("irq", 8'h00, {7'h00, irq});
    $display("test busy done");
  endtask
  // Own address in slave receive, acknowledged, cleared by read then write
  task automatic t_match();
    wr(REG_SADDR, 8'h2a);
    wr(REG_CTRL, 8'h00);
    bus_u.start_cond();
    bus_u.send_byte(8'h54, 1'b0, ack);
    chk("ack driven", 8'h00, {7'h00, ack});
    bus_u.stop_cond();
    settle();
    rc("status", REG_STATUS, 8'h34);
    wr(REG_STATUS, 8'h22);
    rc("status", REG_STATUS, 8'h30);
    $display("test match done");
  endtask
  // General call with no-acknowledge setting, cleared by a data read
  task automatic t_gencall();
    wr(REG_STATUS, 8'h21);
    bus_u.start_cond();
    bus_u.send_byte(8'h00, 1'b0, ack);
    chk("ack driven", 8'h01, {7'h00, ack});
    bus_u.stop_cond();
    settle();
    rc("status", REG_STATUS, 8'h37);
    rc("data", REG_DATA, 8'h00);
    rc("status", REG_STATUS, 8'h31);
    $display("test general call done");
  endtask
  // Data write in transmit mode clears flags; receiver response captured
  task automatic t_tx();
    wr(REG_STATUS, 8'h20);
    bus_u.start_cond();
    bus_u.send_byte(8'h00, 1'b0, ack);
    bus_u.stop_cond();
    // Unarmed status write leaves both address flags set
    wr(REG_STATUS, 8'h20);
    rc("status", REG_STATUS, 8'h36);
    wr(REG_CTRL, 8'h01);
    wr(REG_DATA, 8'h55);
    rc("status", REG_STATUS, 8'h30);
    bus_u.start_cond();
    bus_u.send_byte(8'hff, 1'b0, ack);
    bus_u.stop_cond();
    settle();
    rc("status", REG_STATUS, 8'h31);
    bus_u.start_cond();
    bus_u.send_byte(8'hff, 1'b1, ack);
    bus_u.stop_cond();
    settle();
    rc("status", REG_STATUS, 8'h30);
    $display("test transmit done");
  endtask
  // Master transmitter sees a low line while sending high
  task automatic t_arb();
    wr(REG_CTRL, 8'h03);
    wr(REG_MASK, 8'h04);
    rc("events", REG_EVENT, 8'h0b);
    @(posedge sys_clk);
    tx_drive <= 1'b1;
    tx_bit <= 1'b1;
    bus_u.start_cond();
    bus_u.clock_bit(1'b0, ack);
    // A low bit after the loss must not be driven
    @(posedge sys_clk);
    tx_bit <= 1'b0;
    settle();
    chk("drive", 8'h00, {7'h00, sda_oe});
    @(posedge sys_clk);
    tx_drive <= 1'b0;
    bus_u.stop_cond();
    settle();
    chk("irq", 8'h01, {7'h00, irq});
    rc("status", REG_STATUS, 8'h38);
    rc("events", REG_EVENT, 8'h07);
    wr(REG_STATUS, 8'h20);
    rc("status", REG_STATUS, 8'h30);
    $display("test arbitration done");
  endtask
  // Software start and stop requests through the prohibit bit
  task automatic t_req();
    @(posedge sys_clk);
    tx_drive <= 1'b0;
    wr(REG_CTRL, 8'h00);
    wr(REG_STATUS, 8'h80);
    req(2'b10);
    wr(REG_STATUS, 8'h00);
    req(2'b01);
    $display("test requests done");
  endtask
  // Counts, verdict and end of run
  task automatic final_report();
    $display("checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // 125 MHz system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Main sequence after a 20-cycle reset
  initial
  begin
    sys_rst = 1'b1;
    addr = 3'h0;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    tx_bit = 1'b0;
    tx_drive = 1'b0;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_busy();
    t_match();
    t_gencall();
    t_tx();
    t_arb();
    t_req();
    final_report();
  end
  // Watchdog well beyond the expected 9 us of traffic
  initial
  begin
    #400000;
    err_count++;
    final_report();
  end
endmodule

// File: verilog/i2c_flags_pkg.sv
// Package: register map, bit positions and carrier types of the two-wire status flags
package i2c_flags_pkg;
  // Register indices on the 3-bit register port
  localparam logic [2:0] REG_STATUS = 3'h0;
  localparam logic [2:0] REG_DATA = 3'h1;
  localparam logic [2:0] REG_CTRL = 3'h2;
  localparam logic [2:0] REG_SADDR = 3'h3;
  localparam logic [2:0] REG_EVENT = 3'h4;
  localparam logic [2:0] REG_MASK = 3'h5;
  // Bit positions of serial_bus_status
  localparam int ST_BUSY = 7;
  localparam int ST_SCP = 5;
  localparam int ST_AL = 3;
  localparam int ST_AAS = 2;
  localparam int ST_ADZ = 1;
  localparam int ST_ACK = 0;
  // Bit positions of the control register
  localparam int CT_TX = 0;
  localparam int CT_MST = 1;
  // Bit positions of the event and mask registers
  localparam int EV_START = 0;
  localparam int EV_STOP = 1;
  localparam int EV_AL = 2;
  localparam int EV_MATCH = 3;
  localparam int EV_W = 4;
  // Constants of the bus protocol
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [6:0] SADDR_RESET = 7'h00;
  // Fixed fields of the status read-back
  localparam logic STATUS_IRQ_RD = 1'h0;
  localparam logic STATUS_ONE_RD = 1'h1;
  // Hardware flags of the status register
  typedef struct packed {
    logic busy;
    logic al;
    logic own_address_match;
    logic general_call_seen;
    logic ack;
  } status_flags_t;
  // Read-1 arming of the software-cleared flags
  typedef struct packed {
    logic al;
    logic own_address_match;
    logic general_call_seen;
  } clear_arm_t;
endpackage

// File: verilog/i2c_status_flags.sv
// Status flags of a two-wire serial bus interface with bus watcher and register port
`timescale 1ns/1ps
module i2c_status_flags
  import i2c_flags_pkg::*;
#(
  parameter int SYNC_STAGES = 2 // Pin synchroniser depth
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic tx_bit,
  input wire logic tx_drive,
  output logic start_req,
  output logic stop_req,
  output logic irq
);
  // Elaboration check on the synchroniser depth
  if (SYNC_STAGES != 2)
  begin : g_bad
    $error("SYNC_STAGES must be 2");
  end

  // True when a 7-bit address is the general call
  function automatic logic is_gen_call(input logic [6:0] a);
    is_gen_call = (a == GEN_CALL_ADDR);
  endfunction

  // Pin synchronisers, index 0 is clock line, 1 is data line
  logic [1:0] pin_raw;
  logic [1:0] sync1; // First stage, read only by sync2
  logic [1:0] sync2; // Second stage, safe to use
  logic [1:0] prev; // Previous synchronised level
  assign pin_raw = {sda_in, scl_in};
  genvar gi;
  for (gi = 0; gi < 2; gi++)
  begin : g_sync
    // Two flip-flops then an edge register per pin
    always_ff @(posedge sys_clk)
    begin
      if (sys_rst)
      begin
        sync1[gi] <= 1'b1;
        sync2[gi] <= 1'b1;
        prev[gi] <= 1'b1;
      end
      else
      begin
        sync1[gi] <= pin_raw[gi];
        sync2[gi] <= sync1[gi];
        prev[gi] <= sync2[gi];
      end
    end
  end

  // Bus conditions seen on the synchronised lines
  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
  assign scl_s = sync2[0];
  assign sda_s = sync2[1];
  assign scl_rise = scl_s & ~prev[0];
  assign scl_fall = ~scl_s & prev[0];
  assign start_det = scl_s & prev[0] & prev[1] & ~sda_s;
  assign stop_det = scl_s & prev[0] & ~prev[1] & sda_s;

  // Register state
  status_flags_t flags, next_flags; // Hardware flags
  clear_arm_t arm, next_arm; // Flags read as 1
  logic [1:0] ctrl, next_ctrl; // Transmit and master mode
  logic [6:0] saddr, next_saddr; // Own slave address
  logic [EV_W-1:0] events, next_events; // Sticky events
  logic [EV_W-1:0] mask, next_mask; // Interrupt mask
  logic [7:0] rx_byte, next_rx_byte; // Last received byte
  logic [7:0] rd_q, next_rd_q; // Read data register
  logic start_q, next_start_q, stop_q, next_stop_q;
  // Bit tracking state
  logic [3:0] bit_cnt, next_bit_cnt; // Clock rises in byte
  logic first_byte, next_first_byte; // Address byte pending
  logic ack_phase, next_ack_phase; // Acknowledge clock window
  logic addressed, next_addressed; // Slave selected this transfer
  logic [7:0] shift, next_shift; // Incoming bits
  logic oe_q, next_oe_q; // Data line pull-down

  // Decoded accesses
  logic wr_st, rd_st, wr_dat, rd_dat, tx_mode, mst_mode;
  assign wr_st = wr_en & (addr == REG_STATUS);
  assign rd_st = rd_en & (addr == REG_STATUS);
  assign wr_dat = wr_en & (addr == REG_DATA);
  assign rd_dat = rd_en & (addr == REG_DATA);
  assign tx_mode = ctrl[CT_TX];
  assign mst_mode = ctrl[CT_MST];

  // Events of the current cycle
  logic byte_done, addr_hit, gc_hit, al_hit, data_clr;
  logic ack_drive, tx_low;
  assign byte_done = scl_rise & (bit_cnt == LAST_DATA_BIT);
  // Slave in either transfer direction sees its address or the general call
  // At the eighth rise the seven address bits already sit in the shifter
  assign gc_hit = byte_done & first_byte & ~mst_mode & is_gen_call(shift[6:0]);
  assign addr_hit = byte_done & first_byte & ~mst_mode
    & (is_gen_call(shift[6:0]) | (shift[6:0] == saddr));
  // Master transmitter drives high but the bus reads low
  assign al_hit = mst_mode & tx_mode & ~ack_phase & tx_drive & tx_bit
    & scl_s & ~sda_s & ~flags.al;
  // Data register access that retires the address flags
  assign data_clr = (wr_dat & tx_mode) | (rd_dat & ~tx_mode);
  // Receiver drives the stored acknowledge in the ack window
  assign ack_drive = ack_phase & ~tx_mode & (mst_mode | addressed) & ~flags.ack;
  assign tx_low = mst_mode & tx_mode & ~ack_phase & tx_drive & ~tx_bit & ~flags.al;

  // Bit counter, shifter and acknowledge window
  always_comb
  begin
    next_bit_cnt = bit_cnt;
    next_first_byte = first_byte;
    next_ack_phase = ack_phase;
    next_addressed = addressed;
    next_shift = shift;
    next_rx_byte = rx_byte;
    if (start_det)
    begin
      // New transfer restarts the byte
      next_bit_cnt = 4'h0;
      next_first_byte = 1'b1;
      next_ack_phase = 1'b0;
      next_addressed = 1'b0;
    end
    else if (stop_det)
    begin
      // Bus released
      next_first_byte = 1'b0;
      next_ack_phase = 1'b0;
      next_addressed = 1'b0;
    end
    else
    begin
      if (scl_rise)
      begin
        if (bit_cnt == ACK_SLOT)
        begin
          next_bit_cnt = 4'h0;
          next_first_byte = 1'b0;
        end
        else
        begin
          next_bit_cnt = bit_cnt + 4'h1;
          next_shift = {shift[6:0], sda_s};
        end
      end
      if (byte_done)
      begin
        next_rx_byte = {shift[6:0], sda_s};
      end
      if (addr_hit)
      begin
        next_addressed = 1'b1;
      end
      if (scl_fall)
      begin
        next_ack_phase = (bit_cnt == ACK_SLOT);
      end
    end
  end

  // Flags, arming and control registers
  always_comb
  begin
    next_flags = flags;
    next_arm = arm;
    next_ctrl = ctrl;
    next_saddr = saddr;
    next_mask = mask;
    next_start_q = 1'b0;
    next_stop_q = 1'b0;
    // Status read arms each software-cleared flag that reads as 1
    if (rd_st)
    begin
      next_arm.al = arm.al | flags.al;
      next_arm.own_address_match = arm.own_address_match | flags.own_address_match;
      next_arm.general_call_seen = arm.general_call_seen | flags.general_call_seen;
    end
    if (wr_st)
    begin
      // Only armed flags clear, and only to 0; a written 1 is ignored
      if (arm.al & ~wr_data[ST_AL])
        next_flags.al = 1'b0;
      if (arm.own_address_match & ~wr_data[ST_AAS])
        next_flags.own_address_match = 1'b0;
      if (arm.general_call_seen & ~wr_data[ST_ADZ])
        next_flags.general_call_seen = 1'b0;
      next_arm = '0;
      // Acknowledge setting is software written
      next_flags.ack = wr_data[ST_ACK];
      // Prohibit low requests start or stop by occupied bit
      if (~wr_data[ST_SCP])
      begin
        next_start_q = wr_data[ST_BUSY];
        next_stop_q = ~wr_data[ST_BUSY];
      end
    end
    if (data_clr)
    begin
      next_flags.own_address_match = 1'b0;
      next_flags.general_call_seen = 1'b0;
    end
    // Transmitter captures the receiver answer at the ack clock
    if (scl_rise & (bit_cnt == ACK_SLOT) & tx_mode)
      next_flags.ack = sda_s;
    // Hardware sets win over every clear
    if (al_hit)
      next_flags.al = 1'b1;
    if (addr_hit)
      next_flags.own_address_match = 1'b1;
    if (gc_hit)
      next_flags.general_call_seen = 1'b1;
    if (start_det)
      next_flags.busy = 1'b1;
    else if (stop_det)
      next_flags.busy = 1'b0;
    // Plain control registers
    if (wr_en & (addr == REG_CTRL))
      next_ctrl = wr_data[1:0];
    if (wr_en & (addr == REG_SADDR))
      next_saddr = wr_data[6:0];
    if (wr_en & (addr == REG_MASK))
      next_mask = wr_data[EV_W-1:0];
  end

  // Sticky events, read clears, a new event wins
  logic [EV_W-1:0] ev_now;
  assign ev_now = {addr_hit, al_hit, stop_det, start_det};
  always_comb
  begin
    next_events = events;
    if (rd_en & (addr == REG_EVENT))
      next_events = '0;
    next_events = next_events | ev_now;
  end

  // Read mux, data one cycle after the strobe
  always_comb
  begin
    next_rd_q = 8'h00;
    if (rd_en)
    begin
      case (addr)
        REG_STATUS: next_rd_q = {flags.busy, STATUS_IRQ_RD, STATUS_ONE_RD, STATUS_ONE_RD,
                                 flags.al, flags.own_address_match, flags.general_call_seen, flags.ack};
        REG_DATA: next_rd_q = rx_byte;
        REG_CTRL: next_rd_q = {6'h00, ctrl};
        REG_SADDR: next_rd_q = {1'b0, saddr};
        REG_EVENT: next_rd_q = {{(8-EV_W){1'b0}}, events};
        REG_MASK: next_rd_q = {{(8-EV_W){1'b0}}, mask};
        default: next_rd_q = 8'h00;
      endcase
    end
    // Open-drain pull-down for ack or master data
    next_oe_q = ack_drive | tx_low;
  end

  // Register all state
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      flags <= '0;
      arm <= '0;
      ctrl <= 2'h0;
      saddr <= SADDR_RESET;
      events <= '0;
      mask <= '0;
      rx_byte <= 8'h00;
      rd_q <= 8'h00;
      start_q <= 1'b0;
      stop_q <= 1'b0;
      bit_cnt <= 4'h0;
      first_byte <= 1'b0;
      ack_phase <= 1'b0;
      addressed <= 1'b0;
      shift <= 8'h00;
      oe_q <= 1'b0;
    end
    else
    begin
      flags <= next_flags;
      arm <= next_arm;
      ctrl <= next_ctrl;
      saddr <= next_saddr;
      events <= next_events;
      mask <= next_mask;
      rx_byte <= next_rx_byte;
      rd_q <= next_rd_q;
      start_q <= next_start_q;
      stop_q <= next_stop_q;
      bit_cnt <= next_bit_cnt;
      first_byte <= next_first_byte;
      ack_phase <= next_ack_phase;
      addressed <= next_addressed;
      shift <= next_shift;
      oe_q <= next_oe_q;
    end
  end

  // Outputs
  assign rd_data = rd_q;
  assign sda_out = 1'b0;
  assign sda_oe = oe_q;
  assign start_req = start_q;
  assign stop_req = stop_q;
  assign irq = |(events & mask);

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_ack_drive_low: assert property (ack_drive |=> sda_oe)
    else $error("ack low not driven");
  a_nack_release: assert property (ack_phase & ~tx_mode & flags.ack & ~tx_low |=> ~sda_oe)
    else $error("nack drove line");
  a_ack_capture: assert property (scl_rise & (bit_cnt == ACK_SLOT) & tx_mode |=> flags.ack == $past(sda_s))
    else $error("ack not captured");
  a_gencall_set: assert property (gc_hit |=> flags.general_call_seen & flags.own_address_match)
    else $error("general call flag not set");
  a_match_clear: assert property (data_clr & ~addr_hit |=> ~flags.own_address_match & ~flags.general_call_seen)
    else $error("data access left match flag");
  a_match_set: assert property (addr_hit |=> flags.own_address_match & events[EV_MATCH])
    else $error("match flag not set");
  a_unarmed_hold: assert property (wr_st & ~arm.own_address_match & flags.own_address_match & ~data_clr |=> flags.own_address_match)
    else $error("unarmed clear took effect");
  a_busy_start: assert property (start_det |=> flags.busy)
    else $error("start missed");
  a_busy_stop: assert property (stop_det |=> ~flags.busy)
    else $error("stop missed");
  a_no_write_one: assert property (wr_st & ~flags.al & ~al_hit |=> ~flags.al)
    else $error("flag set by software");
  a_arb_lost: assert property (al_hit |=> flags.al ##1 (~sda_oe || !$past(tx_mode)))
    else $error("arbitration loss missed");
  a_scp_start: assert property (wr_st & ~wr_data[ST_SCP] & wr_data[ST_BUSY] |=> start_req & ~stop_req)
    else $error("start request missing");

  c_start_stop: cover property (start_det ##[1:1000] stop_det);
  c_addr_match: cover property (addr_hit);
  c_arb_lost: cover property (al_hit);
endmodule
